// >>> rtl/rcr_pkg.sv
// Constants and types for the RTC control-register block
// Assumes a 32.768 kHz crystal time base sampled by the core clock
package rcr_pkg;

    // ==================================================
    // Register map
    localparam logic [3:0] ADDR_CTRL_ONE  = 4'hE;
    localparam logic [3:0] ADDR_CTRL_TWO  = 4'hF;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h10;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // ==================================================
    // Periodic interrupt select codes
    localparam logic [2:0] SEL_OFF   = 3'h0;
    localparam logic [2:0] SEL_LOW   = 3'h1;
    localparam logic [2:0] SEL_2HZ   = 3'h2;
    localparam logic [2:0] SEL_1HZ   = 3'h3;
    localparam logic [2:0] SEL_SEC   = 3'h4;
    localparam logic [2:0] SEL_MIN   = 3'h5;
    localparam logic [2:0] SEL_HOUR  = 3'h6;
    localparam logic [2:0] SEL_MONTH = 3'h7;

    // ==================================================
    // Timing: crystal rate in Hz, delays in us, period in s, limits in crystal ticks
    localparam int XTAL_HZ         = 32768;
    localparam int INC_DELAY_US    = 92;
    localparam int INC_DELAY_TICKS = INC_DELAY_US * XTAL_HZ / 1000000;
    localparam int ADJ_PERIOD_S    = 20;
    localparam int ADJ_MAX_US      = 3784;
    localparam int ADJ_MAX_TICKS   = ADJ_MAX_US * XTAL_HZ / 1000000;

    // ==================================================
    // Hour coding
    localparam logic [4:0] HOUR_ZERO = 5'h00;
    localparam logic [4:0] HOUR_TEN  = 5'h0A;
    localparam logic [4:0] HOUR_NOON = 5'h0C;
    localparam logic [5:0] PM_FLAG   = 6'h20;
    localparam logic [5:0] NOON_BCD  = 6'h12;
    localparam logic [5:0] NOON_CODE = 6'h32;

    // ==================================================
    // Types
    typedef enum logic [3:0] {
        MODE_OFF   = 4'h1,
        MODE_LOW   = 4'h2,
        MODE_PULSE = 4'h4,
        MODE_LEVEL = 4'h8
    } rcr_mode_t;

    typedef struct packed {
        logic       weeklyAlarmEnable;
        logic       dailyAlarmEnable;
        logic       hourMode24;
        logic       clockOutDisableB;
        logic       testMode;
        logic       periodicSelectHi;
        logic       periodicSelectMid;
        logic       periodicSelectLo;
    } rcr_ctrl_one_t;

    typedef struct packed {
        logic       thresholdSelect;
        logic       voltageLowFlag;
        logic       scratch;
        logic       oscillationHaltFlag;
        logic       clockOutDisableA;
        logic       periodicIrqFlag;
        logic       weeklyAlarmFlag;
        logic       dailyAlarmFlag;
    } rcr_ctrl_two_t;

    typedef struct packed {
        logic       minuteRoll;
        logic       hourRoll;
        logic       monthRoll;
    } rcr_marks_t;

    typedef struct packed {
        logic       xtal;
        logic       clock_out_control_pin;
        logic       halt;
        logic       vlow;
    } rcr_pins_t;

    // ==================================================
    // Functions
    function automatic rcr_mode_t modeOf(input logic [2:0] sel);
        case (sel)
            SEL_OFF:          modeOf = MODE_OFF;
            SEL_LOW:          modeOf = MODE_LOW;
            SEL_2HZ, SEL_1HZ: modeOf = MODE_PULSE;
            default:          modeOf = MODE_LEVEL;
        endcase
    endfunction

    function automatic logic [5:0] hour12Code(input logic [5:0] bcd24);
        logic [4:0] bin;
        logic [4:0] hr;
        logic [5:0] code;
        bin  = 5'(bcd24[5:4]) * HOUR_TEN + 5'(bcd24[3:0]);
        hr   = (bin == HOUR_ZERO) ? HOUR_NOON : ((bin > HOUR_NOON) ? bin - HOUR_NOON : bin);
        code = (hr >= HOUR_TEN) ? {2'h1, 4'(hr - HOUR_TEN)} : {2'h0, hr[3:0]};
        hour12Code = (bin >= HOUR_NOON) ? (code | PM_FLAG) : code;
    endfunction

endpackage

// >>> rtl/rcr_divider.sv
// Sub-second divider: second increment, pulse waveforms, periodic adjustment
// Assumes a one-cycle crystal tick from the core-clock domain
module rcr_divider import rcr_pkg::*; #(
    parameter int SEC_TICKS = XTAL_HZ
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              xtalTick,
    input  wire logic              restart,
    input  wire logic signed [7:0] adjTicks,
    output logic                   secondTick,
    output logic                   wave1HzLow,
    output logic                   wave2HzLow
);
    localparam int CNT_W = $clog2(SEC_TICKS);
    localparam int SM_W  = $clog2(ADJ_PERIOD_S);
    localparam logic [CNT_W-1:0] LAST  = CNT_W'(SEC_TICKS - 1);
    localparam logic [CNT_W-1:0] HALF  = CNT_W'(SEC_TICKS / 2);
    localparam logic [CNT_W-1:0] QTR   = CNT_W'(SEC_TICKS / 4);
    localparam logic [CNT_W-1:0] INC   = CNT_W'(INC_DELAY_TICKS);
    localparam logic [CNT_W-1:0] ADJPT = CNT_W'(INC_DELAY_TICKS + 1);
    localparam logic [CNT_W-1:0] ONE   = CNT_W'(1);

    typedef struct packed {
        logic [CNT_W-1:0] subCnt;
        logic [7:0]       stall;
        logic [SM_W-1:0]  secMod;
        logic             tickOut;
    } rcr_div_state_t;

    rcr_div_state_t q;
    rcr_div_state_t d;
    logic [7:0]     mag;

    // ==================================================
    // Clamped adjustment magnitude
    function automatic logic [7:0] adjMag(input logic signed [7:0] a);
        logic [7:0] m;
        m = a[7] ? 8'(-a) : 8'(a);
        adjMag = (m > 8'(ADJ_MAX_TICKS)) ? 8'(ADJ_MAX_TICKS) : m;
    endfunction

    // ==================================================
    // Next state
    always_comb begin
        d = q;
        d.tickOut = 1'b0;
        mag = adjMag(adjTicks);
        if (restart) begin
            d.subCnt = '0;
            d.stall  = '0;
        end else if (xtalTick) begin
            if (q.stall != 8'h00) begin
                d.stall = q.stall - 8'h01;
            end else if (q.subCnt == LAST) begin
                d.subCnt = '0;
                d.secMod = (q.secMod == SM_W'(ADJ_PERIOD_S - 1)) ? '0 : q.secMod + SM_W'(1);
            end else if (q.secMod == '0 && q.subCnt == ADJPT) begin
                if (adjTicks[7]) begin
                    d.subCnt = q.subCnt + ONE + CNT_W'(mag);
                end else begin
                    d.subCnt = q.subCnt + ONE;
                    d.stall  = mag;
                end
            end else begin
                d.subCnt  = q.subCnt + ONE;
                d.tickOut = (q.subCnt == INC - ONE);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign secondTick = q.tickOut;
    assign wave1HzLow = q.subCnt < HALF;
    assign wave2HzLow = (q.subCnt < QTR) || (q.subCnt >= HALF && q.subCnt < HALF + QTR);

    // ==================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    restart_zero_a:
    assert property (clkEn && restart |=> q.subCnt == '0 && wave1HzLow && wave2HzLow)
        else $error("divider not cleared by second write");
    adj_bound_a:
    assert property (q.stall <= 8'(ADJ_MAX_TICKS))
        else $error("adjustment stall beyond limit");
    inc_delay_a:
    assert property (secondTick |-> q.subCnt == INC && wave1HzLow)
        else $error("second increment not at delay point");
    adj_stall_c:
    cover property (q.stall != 8'h00);
endmodule

// >>> rtl/rcr_ctrl_regs.sv
// Control registers one and two of the RTC with periodic interrupt logic
// Assumes a register port on core_clk; pins and crystal arrive asynchronously
//
// Overview of operation
// - Control one at E: alarm enables, hour mode, clock disable, test, select.
// - Each alarm enable gates its alarm interrupt; weekly D7, daily D6.
// - Hour-mode bit D5: zero means 12-hour with AM/PM, one 24-hour.
// - 12-hour code: midnight 12, noon 32, PM hours 21 to 31.
// - Slow clock out runs when pin high and either disable bit is zero.
// - Test bit zero is normal operation; host keeps it zero.
// - Select 000 off, 001 low, 010 2Hz, 011 1Hz at half duty.
// - Select 100-111 level interrupts per second, minute, hour, month.
// - Level mode interrupt falls one core clock after the second increment.
// - Pulse mode: second increments about 92us after falling edge.
// - Adjustment alters low period or second by up to 3.784ms every 20s.
// - Second write clears sub-second divider; pulse output goes low.
// - Halt event loads control one zero and control two 10h.
// - Control two at F: threshold, low flag, scratch, halt, disable, flags.
// - Threshold select zero picks 2.1 volts, one picks 1.6 volts.
// - Level mode: periodic flag accepts only zero, releasing the output.
// - Halt clears adjustment and controls, stops interrupt, enables slow clock.
// - Voltage-low flag sticks and stops monitoring until written zero.
module rcr_ctrl_regs import rcr_pkg::*; #(
    parameter int SEC_TICKS = XTAL_HZ
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              xtalClkPin,
    input  wire logic              clockOutControlPin,
    input  wire logic              oscHaltPin,
    input  wire logic              supplyLowPin,
    input  wire logic              regWrEn,
    input  wire logic [3:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              secondWrite,
    input  wire logic signed [7:0] adjTicks,
    input  wire rcr_marks_t        marks,
    input  wire logic              weeklyMatch,
    input  wire logic              dailyMatch,
    input  wire logic [5:0]        hourBcd24,
    output logic [7:0]             regRdData,
    output logic                   secondTick,
    output logic                   adjClear,
    output logic [5:0]             hourDisplay,
    output logic                   hourMode24,
    output logic                   thresholdSelect,
    output logic                   testMode,
    output logic                   slowClockOutput,
    output logic                   interruptOutN
);

    typedef struct packed {
        rcr_pins_t     sync1;
        rcr_pins_t     sync2;
        logic          prevXtal;
        logic          prevHalt;
        rcr_ctrl_one_t one;
        rcr_ctrl_two_t two;
        logic [7:0]    rdData;
        logic [5:0]    hourDisp;
        logic          clkOut;
        logic          intrN;
        logic          adjClr;
    } rcr_main_state_t;

    localparam rcr_main_state_t STATE_RESET = '{
        one:     CTRL_ONE_RESET,
        two:     CTRL_TWO_RESET,
        intrN:   1'b1,
        default: '0
    };

    rcr_main_state_t q;
    rcr_main_state_t d;
    rcr_ctrl_two_t   wrTwo;
    rcr_mode_t       mode;
    logic [2:0]      sel;
    logic            xtalTick;
    logic            haltRise;
    logic            wrOne;
    logic            wrTwoEn;
    logic            levelHit;
    logic            wave1HzLow;
    logic            wave2HzLow;

    // ==================================================
    // Divider
    rcr_divider #(
        .SEC_TICKS (SEC_TICKS)
    ) u_divider (
        .core_clk   (core_clk),
        .rst        (rst),
        .clkEn      (clkEn),
        .xtalTick   (xtalTick),
        .restart    (secondWrite),
        .adjTicks   (adjTicks),
        .secondTick (secondTick),
        .wave1HzLow (wave1HzLow),
        .wave2HzLow (wave2HzLow)
    );

    // ==================================================
    // Decode
    assign xtalTick = q.sync2.xtal && !q.prevXtal;
    assign haltRise = q.sync2.halt && !q.prevHalt;
    assign wrOne    = regWrEn && regAddr == ADDR_CTRL_ONE;
    assign wrTwoEn  = regWrEn && regAddr == ADDR_CTRL_TWO;
    assign wrTwo    = rcr_ctrl_two_t'(regWrData);
    assign sel      = {q.one.periodicSelectHi, q.one.periodicSelectMid, q.one.periodicSelectLo};
    assign mode     = modeOf(sel);
    assign levelHit = (sel == SEL_SEC)
                   || (sel == SEL_MIN && marks.minuteRoll)
                   || (sel == SEL_HOUR && marks.hourRoll)
                   || (sel == SEL_MONTH && marks.monthRoll);

    // ==================================================
    // Next state
    always_comb begin
        d = q;
        d.sync1    = {xtalClkPin, clockOutControlPin, oscHaltPin, supplyLowPin};
        d.sync2    = q.sync1;
        d.prevXtal = q.sync2.xtal;
        d.prevHalt = q.sync2.halt;
        d.adjClr   = 1'b0;

        // Register writes
        if (wrOne) begin
            d.one = rcr_ctrl_one_t'(regWrData);
        end
        if (wrTwoEn) begin
            d.two.thresholdSelect  = wrTwo.thresholdSelect;
            d.two.scratch          = wrTwo.scratch;
            d.two.clockOutDisableA = wrTwo.clockOutDisableA;
            if (!wrTwo.voltageLowFlag) begin
                d.two.voltageLowFlag = 1'b0;
            end
            if (!wrTwo.oscillationHaltFlag) begin
                d.two.oscillationHaltFlag = 1'b0;
            end
            if (!wrTwo.periodicIrqFlag && mode == MODE_LEVEL) begin
                d.two.periodicIrqFlag = 1'b0;
            end
            if (!wrTwo.weeklyAlarmFlag) begin
                d.two.weeklyAlarmFlag = 1'b0;
            end
            if (!wrTwo.dailyAlarmFlag) begin
                d.two.dailyAlarmFlag = 1'b0;
            end
        end

        // Supply monitor runs only while the flag is clear
        if (q.sync2.vlow && !q.two.voltageLowFlag) begin
            d.two.voltageLowFlag = 1'b1;
        end

        // Periodic interrupt source
        case (mode)
            MODE_LEVEL: begin
                if (secondTick && levelHit) begin
                    d.two.periodicIrqFlag = 1'b1;
                end
            end
            MODE_PULSE: begin
                d.two.periodicIrqFlag = (sel == SEL_2HZ) ? wave2HzLow : wave1HzLow;
            end
            MODE_LOW: begin
                d.two.periodicIrqFlag = 1'b1;
            end
            default: begin
                d.two.periodicIrqFlag = 1'b0;
            end
        endcase

        // Alarm flags, set wins over clear, forced low when disabled
        if (weeklyMatch) begin
            d.two.weeklyAlarmFlag = 1'b1;
        end
        if (dailyMatch) begin
            d.two.dailyAlarmFlag = 1'b1;
        end
        if (!d.one.weeklyAlarmEnable) begin
            d.two.weeklyAlarmFlag = 1'b0;
        end
        if (!d.one.dailyAlarmEnable) begin
            d.two.dailyAlarmFlag = 1'b0;
        end

        // Oscillation halt loads defaults above everything else
        if (haltRise) begin
            d.one    = rcr_ctrl_one_t'(CTRL_ONE_RESET);
            d.two    = rcr_ctrl_two_t'(CTRL_TWO_RESET);
            d.adjClr = 1'b1;
        end

        // Outputs
        d.clkOut = q.sync2.xtal && q.sync2.clock_out_control_pin
                && !(d.one.clockOutDisableB && d.two.clockOutDisableA);
        d.intrN  = !(d.two.periodicIrqFlag || d.two.weeklyAlarmFlag
                || d.two.dailyAlarmFlag);
        d.hourDisp = d.one.hourMode24 ? hourBcd24 : hour12Code(hourBcd24);
        case (regAddr)
            ADDR_CTRL_ONE: d.rdData = q.one;
            ADDR_CTRL_TWO: d.rdData = q.two;
            default:       d.rdData = UNMAPPED_READ;
        endcase
    end

    // ==================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= STATE_RESET;
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign regRdData       = q.rdData;
    assign adjClear        = q.adjClr;
    assign hourDisplay     = q.hourDisp;
    assign hourMode24      = q.one.hourMode24;
    assign thresholdSelect = q.two.thresholdSelect;
    assign testMode        = q.one.testMode;
    assign slowClockOutput = q.clkOut;
    assign interruptOutN   = q.intrN;

    // ==================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ctrl_readback_a:
    assert property (clkEn && wrOne && !haltRise |=> q.one == $past(regWrData))
        else $error("control one does not hold written value");
    alarm_enable_a:
    assert property ((q.one.weeklyAlarmEnable || !q.two.weeklyAlarmFlag)
                  && (q.one.dailyAlarmEnable || !q.two.dailyAlarmFlag))
        else $error("alarm flag set while its enable is off");
    hour_mode_a:
    assert property (clkEn && !regWrEn && !haltRise && q.one.hourMode24
                     |=> hourDisplay == $past(hourBcd24))
        else $error("24-hour code altered");
    hour_noon_a:
    assert property (clkEn && !regWrEn && !haltRise && !q.one.hourMode24
                     && hourBcd24 == NOON_BCD |=> hourDisplay == NOON_CODE)
        else $error("noon not coded as 32 in 12-hour mode");
    clk_gate_a:
    assert property (clkEn && !q.sync2.clock_out_control_pin |=> !slowClockOutput)
        else $error("slow clock driven while control pin low");
    fixed_low_a:
    assert property (clkEn && !regWrEn && !haltRise && sel == SEL_LOW
                     |=> !interruptOutN && q.two.periodicIrqFlag)
        else $error("select 001 did not hold interrupt low");
    level_fall_a:
    assert property (clkEn && !regWrEn && !haltRise && sel == SEL_SEC && secondTick
                     |=> !interruptOutN
                     ##1 (!interruptOutN || $past(!clkEn || regWrEn || haltRise)))
        else $error("level interrupt not asserted at second increment");
    periodic_irq_flag_clear_a:
    assert property (clkEn && wrTwoEn && !wrTwo.periodicIrqFlag && !haltRise
                     && mode == MODE_LEVEL && !secondTick |=> !q.two.periodicIrqFlag)
        else $error("periodic flag not cleared by written zero");
    periodic_irq_flag_write1_a:
    assert property (clkEn && wrTwoEn && mode == MODE_LEVEL && !q.two.periodicIrqFlag
                     && !secondTick |=> !q.two.periodicIrqFlag)
        else $error("periodic flag set by software");
    vlow_sticky_a:
    assert property (clkEn && q.two.voltageLowFlag && !haltRise
                     && !(wrTwoEn && !wrTwo.voltageLowFlag) |=> q.two.voltageLowFlag)
        else $error("voltage-low flag dropped without a write");
    halt_defaults_a:
    assert property (clkEn && haltRise
                     |=> q.one == CTRL_ONE_RESET && q.two == CTRL_TWO_RESET && adjClear)
        else $error("halt did not load defaults");
    halt_stops_a:
    assert property (clkEn && haltRise |=> interruptOutN)
        else $error("interrupt still active after halt");
    irq_any_a:
    assert property (!interruptOutN == (q.two.periodicIrqFlag || q.two.weeklyAlarmFlag
                                        || q.two.dailyAlarmFlag))
        else $error("interrupt output disagrees with pending sources");

    level_fire_c:
    cover property (mode == MODE_LEVEL && !interruptOutN);
    pulse_low_c:
    cover property (sel == SEL_1HZ && $fell(interruptOutN));
    alarm_set_c:
    cover property (q.two.weeklyAlarmFlag && q.two.dailyAlarmFlag);
    halt_event_c:
    cover property (haltRise);
endmodule

// >>> test/rcr_xtal_model.sv
// Crystal source for the control-register block bench
// Assumes the block samples this pin with its own core clock
module rcr_xtal_model #(
    parameter int HALF_NS = 80
) (
    output logic xtal
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================
    // Free-running oscillator
    initial begin
        xtal = 1'b0;
        forever #(HALF_NS) xtal = ~xtal;
    end
endmodule

// >>> test/rcr_ctrl_regs_test.sv
// Self-checking bench for the control-register block
// Assumes a 64-tick second and a crystal of 160 ns period
module rcr_ctrl_regs_test import rcr_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, clkEn, xtalClkPin, clockOutControlPin, oscHaltPin, supplyLowPin;
    logic regWrEn, secondWrite, weeklyMatch, dailyMatch, secondTick, adjClear;
    logic hourMode24, thresholdSelect, testMode, slowClockOutput, interruptOutN;
    logic [3:0]        regAddr;
    logic [7:0]        regWrData, regRdData, v;
    logic signed [7:0] adjTicks;
    logic [5:0]        hourBcd24, hourDisplay, e;
    rcr_marks_t        marks;
    int                num_errors, total_checks, p, n;
    logic [19:0]       rows [5] = '{20'hEE0E0, 20'hE1010, 20'hFFFB8, 20'hF0000, 20'h3FF00};

    rcr_xtal_model #(.HALF_NS(80)) u_xtal (.xtal(xtalClkPin));
    rcr_ctrl_regs #(.SEC_TICKS(64)) u_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .xtalClkPin(xtalClkPin), .clockOutControlPin(clockOutControlPin),
        .oscHaltPin(oscHaltPin), .supplyLowPin(supplyLowPin), .regWrEn(regWrEn),
        .regAddr(regAddr), .regWrData(regWrData), .secondWrite(secondWrite),
        .adjTicks(adjTicks), .marks(marks), .weeklyMatch(weeklyMatch),
        .dailyMatch(dailyMatch), .hourBcd24(hourBcd24), .regRdData(regRdData),
        .secondTick(secondTick), .adjClear(adjClear), .hourDisplay(hourDisplay),
        .hourMode24(hourMode24), .thresholdSelect(thresholdSelect), .testMode(testMode),
        .slowClockOutput(slowClockOutput), .interruptOutN(interruptOutN));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ==================================================
    // Helpers
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask
    task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
        tick(1);
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        regAddr = a;
        tick(2);
        d = regRdData;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task waiton(input bit sec, input logic lvl);
        n = 0;
        tick(1);
        while ((sec ? secondTick : interruptOutN) !== lvl) begin
            tick(1);
            n++;
            if (n > 1200) begin
                num_errors++;
                tally_and_finish;
            end
        end
    endtask
    task clkrun(input logic exp);
        tick(4);
        n = 0;
        repeat (40) begin
            v[0] = slowClockOutput;
            tick(1);
            if (slowClockOutput !== v[0]) n++;
        end
        chk("slowclk", 8'(n > 0), 8'(exp));
    endtask
    task duty(input logic [2:0] s);
        wr(ADDR_CTRL_ONE, {5'h00, s});
        tick(4);
        p = 0;
        repeat (1024) begin
            tick(1);
            p += int'(interruptOutN === 1'b0);
        end
        chk("duty", 8'(p > 504 && p < 520), 8'h01);
    endtask
    // ==================================================
    // Main sequence
    initial begin
        {rst, clkEn, clockOutControlPin, oscHaltPin, supplyLowPin, regWrEn} = 6'h30;
        {secondWrite, weeklyMatch, dailyMatch, regAddr, regWrData} = '0;
        {adjTicks, hourBcd24, marks, num_errors, total_checks} = '0;
        tick(5);
        rst = 1'b0;
        rd(ADDR_CTRL_ONE, v); chk("ctrl1", v, 8'h00);
        rd(ADDR_CTRL_TWO, v); chk("ctrl2", v, 8'h10);
        chk("interrupt_out_n", 8'(interruptOutN), 8'h01);
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16], v); chk("row", v, rows[i][7:0]);
        end
        chk("test", 8'(testMode), 8'h00);
        $display("register test done");
        for (int h = 0; h < 24; h++) begin
            hourBcd24 = {2'(h / 10), 4'(h % 10)};
            tick(2);
            p = (h % 12 == 0) ? 12 : h % 12;
            e = {2'(p / 10), 4'(p % 10)} | ((h >= 12) ? 6'h20 : 6'h00);
            chk("hour12", {2'h0, hourDisplay}, {2'h0, e});
        end
        wr(ADDR_CTRL_ONE, 8'h20); tick(2);
        chk("hour24", {2'h0, hourDisplay}, 8'h23);
        chk("mode24", 8'(hourMode24), 8'h01);
        $display("hour test done");
        clockOutControlPin = 1'b1;
        wr(ADDR_CTRL_TWO, 8'h08); wr(ADDR_CTRL_ONE, 8'h10); clkrun(1'b0);
        wr(ADDR_CTRL_ONE, 8'h00); clkrun(1'b1);
        wr(ADDR_CTRL_TWO, 8'h00); wr(ADDR_CTRL_ONE, 8'h10); clkrun(1'b1);
        clockOutControlPin = 1'b0; clkrun(1'b0);
        $display("slow clock test done");
        wr(ADDR_CTRL_ONE, {5'h00, SEL_LOW}); tick(4);
        chk("low", 8'(interruptOutN), 8'h00);
        wr(ADDR_CTRL_ONE, {5'h00, SEL_OFF}); tick(4);
        chk("off", 8'(interruptOutN), 8'h01);
        duty(SEL_1HZ);
        duty(SEL_2HZ);
        wr(ADDR_CTRL_ONE, {5'h00, SEL_1HZ}); waiton(1'b0, 1'b1);
        secondWrite = 1'b1; tick(1); secondWrite = 1'b0; tick(3);
        chk("restart", 8'(interruptOutN), 8'h00);
        $display("pulse test done");
        wr(ADDR_CTRL_ONE, {5'h00, SEL_SEC}); wr(ADDR_CTRL_TWO, 8'h00); tick(2);
        chk("release", 8'(interruptOutN), 8'h01);
        waiton(1'b1, 1'b1); tick(1);
        chk("levelsec", 8'(interruptOutN), 8'h00);
        wr(ADDR_CTRL_TWO, 8'h04); tick(2);
        chk("flagone", 8'(interruptOutN), 8'h00);
        for (int c = 5; c < 8; c++) begin
            marks = '0;
            wr(ADDR_CTRL_ONE, 8'(c)); wr(ADDR_CTRL_TWO, 8'h00);
            waiton(1'b1, 1'b1); tick(2);
            chk("noroll", 8'(interruptOutN), 8'h01);
            marks = 3'(1 << (7 - c));
            waiton(1'b1, 1'b1); tick(1);
            chk("roll", 8'(interruptOutN), 8'h00);
        end
        $display("level test done");
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL_ONE, 8'h00); wr(ADDR_CTRL_TWO, 8'h00);
            {weeklyMatch, dailyMatch} = 2'(1 << i); tick(1); {weeklyMatch, dailyMatch} = '0;
            tick(3); chk("alarmoff", 8'(interruptOutN), 8'h01);
            wr(ADDR_CTRL_ONE, 8'(8'h40 << i));
            {weeklyMatch, dailyMatch} = 2'(1 << i); tick(1); {weeklyMatch, dailyMatch} = '0;
            tick(3); chk("alarmon", 8'(interruptOutN), 8'h00);
            rd(ADDR_CTRL_TWO, v); chk("aflag", v, 8'(1 << i));
        end
        $display("alarm test done");
        wr(ADDR_CTRL_ONE, 8'h53); oscHaltPin = 1'b1;
        n = 0;
        while (adjClear !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("adjclear", 8'(adjClear), 8'h01);
        chk("haltintr", 8'(interruptOutN), 8'h01);
        if (adjClear !== 1'b1) tally_and_finish;
        oscHaltPin = 1'b0;
        rd(ADDR_CTRL_ONE, v); chk("haltc1", v, 8'h00);
        rd(ADDR_CTRL_TWO, v); chk("haltc2", v, 8'h10);
        supplyLowPin = 1'b1; tick(5); supplyLowPin = 1'b0; tick(5);
        rd(ADDR_CTRL_TWO, v); chk("vlow", v, 8'h50);
        wr(ADDR_CTRL_TWO, 8'h90); tick(1);
        chk("thresh", 8'(thresholdSelect), 8'h01);
        rd(ADDR_CTRL_TWO, v); chk("vclear", v, 8'h90);
        $display("halt test done");
        adjTicks = 8'sh04;
        wr(ADDR_CTRL_ONE, {5'h00, SEL_1HZ});
        p = 0;
        n = 0;
        repeat (10800) begin
            tick(1);
            n = interruptOutN ? 0 : n + 1;
            if (n > p) p = n;
        end
        chk("adjlow", 8'(p / 8), 8'h24);
        adjTicks = '0;
        $display("adjust test done");
        tally_and_finish;
    end
endmodule
